// >>> rtl/hararb_defs.svh
`ifndef HARARB_DEFS_SVH
`define HARARB_DEFS_SVH

// refresh strobe length in system-clock rising edges
`define HARARB_REFRESH_EDGES     3'h4
// first edge count at which channel ready low no longer stretches the strobe
`define HARARB_STRETCH_EDGE      3'h3
// extra system-clock cycles added when a dma hold waits at the end
`define HARARB_DMA_EXTEND        3'h1
// system-clock periods per internal dma clock period
`define HARARB_DMA_CLK_DIV       2'h2
// synchroniser depth
`define HARARB_SYNC_STAGES       2

`endif

// >>> rtl/hararb_pkg.sv
package hararb_pkg;

    typedef enum logic [2:0] {
        HARARB_IDLE,
        HARARB_WAIT_DMA,
        HARARB_DMA_GRANT,
        HARARB_WAIT_REF,
        HARARB_REFRESH,
        HARARB_REF_EXTEND
    } hararb_state_type;

    typedef struct packed {
        logic dma_hold;
        logic timer_req;
        logic ext_refresh;
    } hararb_req_type;

endpackage : hararb_pkg

// >>> rtl/hararb_sync.sv
`timescale 1ns/1ps
`include "hararb_defs.svh"

// STAGES-deep synchroniser (two by default); only the last stage is visible outside
module hararb_sync #(
    parameter int STAGES = `HARARB_SYNC_STAGES
) (
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    input  wire logic async_i,
    input  wire logic reset_val_i,
    output logic      sync_o
);
    logic [STAGES-1:0] chain_q;
    logic [STAGES-1:0] chain_d;

    // refused at elaboration: a single stage gives no metastability margin
    if (STAGES < 2) begin : g_bad_stages
        $error("hararb_sync needs at least two stages");
    end

    always_comb begin
        chain_d = {chain_q[STAGES-2:0], async_i};
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            chain_q <= '0;
        end else begin
            chain_q <= chain_d;
        end
    end

    assign sync_o = chain_q[STAGES-1] ^ reset_val_i;
endmodule : hararb_sync

// >>> rtl/hararb_top.sv
`timescale 1ns/1ps
`include "hararb_defs.svh"

module hararb_top (
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    input  wire logic dma_hold_req_i,
    input  wire logic timer_out_i,
    input  wire logic cpu_hold_ack_i,
    input  wire logic channel_ready_i,
    input  wire logic refresh_n_i,
    output logic      refresh_n_o,
    output logic      refresh_n_oe_b_o,
    output logic      cpu_hold_request_o,
    output logic      dma_hold_ack_o,
    output logic      dma_clk_o
);
    hararb_pkg::hararb_state_type state_q, state_d;
    wire hararb_pkg::hararb_req_type req_s;
    logic       dma_clk_q, dma_clk_d;
    logic       timer_prev_q, timer_prev_d;
    logic       timer_pend_q, timer_pend_d;
    logic       dma_seen_q, dma_seen_d;
    logic       ext_prev_q, ext_prev_d;
    logic [2:0] edge_cnt_q, edge_cnt_d;
    logic       stretch_q, stretch_d;
    logic       hold_q, hold_d;
    logic       ack_q, ack_d;
    logic       strobe_q, strobe_d;
    logic       timer_s;
    logic       ext_low_s;
    logic       ref_want;

    hararb_sync u_sync_dma (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .async_i     (dma_hold_req_i),
        .reset_val_i (1'b0),
        .sync_o      (req_s.dma_hold)
    );

    hararb_sync u_sync_timer (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .async_i     (timer_out_i),
        .reset_val_i (1'b0),
        .sync_o      (timer_s)
    );

    // inverted through the synchroniser so reset reads as released (high)
    hararb_sync u_sync_ext (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .async_i     (~refresh_n_i),
        .reset_val_i (1'b0),
        .sync_o      (ext_low_s)
    );

    // own drive is excluded so our strobe does not retrigger itself
    assign req_s.ext_refresh = ext_low_s & ~ext_prev_q & ~strobe_q;
    assign req_s.timer_req   = timer_pend_q;
    assign ref_want          = req_s.timer_req;

    always_comb begin
        dma_clk_d    = ~dma_clk_q;
        timer_prev_d = timer_s;
        ext_prev_d   = ext_low_s;
        timer_pend_d = timer_pend_q;
        dma_seen_d   = dma_seen_q;
        state_d      = state_q;
        edge_cnt_d   = edge_cnt_q;
        stretch_d    = stretch_q;
        hold_d       = hold_q;
        ack_d        = ack_q;
        strobe_d     = strobe_q;

        // dma captured on the rising phase of the dma clock
        if (!dma_clk_q) begin
            dma_seen_d = req_s.dma_hold;
        end

        case (state_q)
            hararb_pkg::HARARB_IDLE: begin
                if (dma_seen_q && !timer_pend_q) begin
                    state_d = hararb_pkg::HARARB_WAIT_DMA;
                    hold_d  = 1'b1;
                end else if (timer_pend_q && dma_clk_q) begin
                    state_d = hararb_pkg::HARARB_WAIT_REF;
                    hold_d  = 1'b1;
                end else if (dma_seen_q) begin
                    state_d = hararb_pkg::HARARB_WAIT_DMA;
                    hold_d  = 1'b1;
                end
            end
            hararb_pkg::HARARB_WAIT_DMA: begin
                if (cpu_hold_ack_i) begin
                    state_d = hararb_pkg::HARARB_DMA_GRANT;
                    ack_d   = 1'b1;
                end
            end
            hararb_pkg::HARARB_DMA_GRANT: begin
                if (!req_s.dma_hold) begin
                    ack_d      = 1'b0;
                    dma_seen_d = 1'b0;
                    if (ref_want) begin
                        state_d = hararb_pkg::HARARB_WAIT_REF;
                    end else begin
                        state_d = hararb_pkg::HARARB_IDLE;
                        hold_d  = 1'b0;
                    end
                end
            end
            hararb_pkg::HARARB_WAIT_REF: begin
                if (cpu_hold_ack_i) begin
                    state_d      = hararb_pkg::HARARB_REFRESH;
                    strobe_d     = 1'b1;
                    edge_cnt_d   = 3'h0;
                    stretch_d    = 1'b0;
                    timer_pend_d = 1'b0;
                end
            end
            hararb_pkg::HARARB_REFRESH: begin
                edge_cnt_d = edge_cnt_q + 3'h1;
                if (!channel_ready_i && edge_cnt_q < `HARARB_STRETCH_EDGE) begin
                    stretch_d = 1'b1;
                end
                if (stretch_q) begin
                    edge_cnt_d = edge_cnt_q;
                    if (channel_ready_i) begin
                        stretch_d = 1'b0;
                    end
                end else if (edge_cnt_q + 3'h1 == `HARARB_REFRESH_EDGES) begin
                    if (req_s.dma_hold) begin
                        state_d    = hararb_pkg::HARARB_REF_EXTEND;
                        edge_cnt_d = 3'h0;
                    end else begin
                        state_d  = hararb_pkg::HARARB_IDLE;
                        strobe_d = 1'b0;
                        hold_d   = 1'b0;
                    end
                end
            end
            hararb_pkg::HARARB_REF_EXTEND: begin
                edge_cnt_d = edge_cnt_q + 3'h1;
                if (edge_cnt_q + 3'h1 == `HARARB_DMA_EXTEND) begin
                    strobe_d   = 1'b0;
                    ack_d      = 1'b1;
                    dma_seen_d = 1'b1;
                    state_d    = hararb_pkg::HARARB_DMA_GRANT;
                end
            end
            default: begin
                state_d  = hararb_pkg::HARARB_IDLE;
                hold_d   = 1'b0;
                ack_d    = 1'b0;
                strobe_d = 1'b0;
            end
        endcase

        // sets come after the case so a fresh request beats the clear in one cycle
        // timer rising edge captured on every system clock, whatever the dma clock phase
        if (timer_s && !timer_prev_q) begin
            timer_pend_d = 1'b1;
        end
        if (req_s.ext_refresh) begin
            timer_pend_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_q      <= hararb_pkg::HARARB_IDLE;
            dma_clk_q    <= 1'b0;
            timer_prev_q <= 1'b0;
            ext_prev_q   <= 1'b0;
            timer_pend_q <= 1'b0;
            dma_seen_q   <= 1'b0;
            edge_cnt_q   <= 3'h0;
            stretch_q    <= 1'b0;
            hold_q       <= 1'b0;
            ack_q        <= 1'b0;
            strobe_q     <= 1'b0;
        end else begin
            state_q      <= state_d;
            dma_clk_q    <= dma_clk_d;
            timer_prev_q <= timer_prev_d;
            ext_prev_q   <= ext_prev_d;
            timer_pend_q <= timer_pend_d;
            dma_seen_q   <= dma_seen_d;
            edge_cnt_q   <= edge_cnt_d;
            stretch_q    <= stretch_d;
            hold_q       <= hold_d;
            ack_q        <= ack_d;
            strobe_q     <= strobe_d;
        end
    end

    // open drain: data always low, enable low while pulling
    assign refresh_n_o        = 1'b0;
    assign refresh_n_oe_b_o   = ~strobe_q;
    assign cpu_hold_request_o = hold_q;
    assign dma_hold_ack_o     = ack_q;
    assign dma_clk_o          = dma_clk_q;
endmodule : hararb_top

// >>> sim/hararb_properties.sv
`timescale 1ns/1ps
module hararb_checker (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic cpu_hold_ack_i,
    input wire logic channel_ready_i,
    input wire logic refresh_n_oe_b_o,
    input wire logic cpu_hold_request_o,
    input wire logic dma_hold_ack_o,
    input wire logic dma_clk_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_ack;
        $rose(dma_hold_ack_o) |-> $past(cpu_hold_ack_i) && cpu_hold_request_o;
    endproperty
    a_ack: assert property (p_ack) else $error("dma ack early");
    property p_pull;
        $fell(refresh_n_oe_b_o) |-> $past(cpu_hold_ack_i) && cpu_hold_request_o;
    endproperty
    a_pull: assert property (p_pull) else $error("strobe early");
    property p_len;
        $fell(refresh_n_oe_b_o) |=> !refresh_n_oe_b_o [*3];
    endproperty
    a_len: assert property (p_len) else $error("strobe short");
    property p_stretch;
        $fell(refresh_n_oe_b_o) ##1 !channel_ready_i |=> !refresh_n_oe_b_o [*3];
    endproperty
    a_stretch: assert property (p_stretch) else $error("no stretch");
    property p_drop;
        $fell(cpu_hold_request_o) |-> refresh_n_oe_b_o && !dma_hold_ack_o;
    endproperty
    a_drop: assert property (p_drop) else $error("hold dropped in use");
    property p_keep;
        dma_hold_ack_o || !refresh_n_oe_b_o |-> cpu_hold_request_o;
    endproperty
    a_keep: assert property (p_keep) else $error("grant without hold");
    property p_rst;
        disable iff (1'b0) !rst_b_i |=> !cpu_hold_request_o && !dma_hold_ack_o
            && refresh_n_oe_b_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_div;
        dma_clk_o |=> !dma_clk_o;
    endproperty
    a_div: assert property (p_div) else $error("dma clock rate");
    property p_div_rise;
        !dma_clk_o |=> dma_clk_o;
    endproperty
    a_div_rise: assert property (p_div_rise) else $error("dma clock stuck low");
endmodule : hararb_checker

bind hararb_top hararb_checker hararb_checker_inst (.core_clk_i, .rst_b_i, .cpu_hold_ack_i,
    .channel_ready_i, .refresh_n_oe_b_o, .cpu_hold_request_o, .dma_hold_ack_o, .dma_clk_o);

// >>> sim/hararb_cpu_model.sv
`timescale 1ns/1ps
module hararb_cpu_model (
    input  wire logic core_clk_i,
    input  wire logic hold_req_i,
    input  wire logic slow_i,
    output logic      hold_ack_o
);
    logic [2:0] wait_q = 3'h0;
    initial hold_ack_o = 1'b0;
    // slow mode lets a bus cycle finish first; ack drops one clock after the request
    always @(posedge core_clk_i) begin
        wait_q <= !hold_req_i ? 3'h0 : (wait_q[2] ? wait_q : wait_q + 3'h1);
        hold_ack_o <= hold_req_i && (slow_i ? wait_q[2] : 1'b1);
    end
endmodule : hararb_cpu_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       dma = 1'b0;
    logic       tmr = 1'b0;
    logic       rdy = 1'b1;
    logic       ext_n = 1'b1;
    logic       slow = 1'b0;
    logic       cpu_ack, rf_o, oe_b, hold, ack, dclk;
    logic [2:0] mon;
    int         failures = 0;
    int         checked = 0;
    int         len = 0;
    int         holdfalls = 0;
    int         hf;
    int         exp_q[$];
    // pull-up: wire is low when either side pulls it
    wire rf_wire = (!oe_b && !rf_o) ? 1'b0 : ext_n;
    assign mon = {ack, hold, oe_b};
    always #12.5 clk = ~clk;
    hararb_top hararb_top_inst (.core_clk_i(clk), .rst_b_i(rst_b), .dma_hold_req_i(dma),
        .timer_out_i(tmr), .cpu_hold_ack_i(cpu_ack), .channel_ready_i(rdy),
        .refresh_n_i(rf_wire), .refresh_n_o(rf_o), .refresh_n_oe_b_o(oe_b),
        .cpu_hold_request_o(hold), .dma_hold_ack_o(ack), .dma_clk_o(dclk));
    hararb_cpu_model hararb_cpu_model_inst (.core_clk_i(clk), .hold_req_i(hold),
        .slow_i(slow), .hold_ack_o(cpu_ack));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc
    task automatic tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input bit ok, input string m);
        checked++;
        if (!ok) begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : cmp
    task automatic wait_for(input int b, input logic v);
        int n;
        n = 0;
        while (mon[b] !== v && n < 80) begin
            cyc(1);
            n++;
        end
        if (mon[b] !== v) begin
            cmp(1'b0, "timeout");
            tally_and_finish();
        end
    endtask : wait_for
    task automatic run_refresh(input int k, input bit ext, input bit d);
        exp_q.push_back(4 + k + int'(d));
        ext_n = !ext;
        tmr = !ext;
        wait_for(0, 1'b0);
        cmp(rf_o === 1'b0 && rf_wire === 1'b0, "strobe not pulled low");
        ext_n = 1'b1;
        dma = d;
        if (k > 0) begin
            cyc(1);
            rdy = 1'b0;
            cyc(k);
            rdy = 1'b1;
        end
        if (d) begin
            wait_for(2, 1'b1);
            cmp(oe_b === 1'b1 && hold === 1'b1, "dma after refresh");
            dma = 1'b0;
        end
        wait_for(1, 1'b0);
        cmp(oe_b === 1'b1 && ack === 1'b0, "hold dropped while strobe pulled");
        tmr = 1'b0;
    endtask : run_refresh
    task automatic run_dma(input bit r);
        dma = 1'b1;
        wait_for(2, 1'b1);
        cmp(cpu_ack === 1'b1, "dma ack before cpu ack");
        tmr = r;
        if (r)
            exp_q.push_back(4);
        cyc($urandom_range(6, 2));
        dma = 1'b0;
        wait_for(1, 1'b0);
        tmr = 1'b0;
    endtask : run_dma
    always @(posedge clk) begin
        if (oe_b === 1'b0)
            len <= len + 1;
        else if (len != 0) begin
            cmp(exp_q.size() > 0 && len == exp_q.pop_front(), "strobe length");
            len <= 0;
        end
        if (rst_b && $fell(hold))
            holdfalls <= holdfalls + 1;
    end
    initial begin
        void'($urandom(32'haef41c80));
        cyc(3);
        cmp(hold === 1'b0 && ack === 1'b0 && oe_b === 1'b1, "reset outputs");
        cyc(1);
        rst_b = 1'b1;
        for (int i = 0; i < 12; i++) begin
            slow = 1'($urandom_range(1, 0));
            hf = holdfalls;
            case (i % 6)
                0: run_refresh(0, 1'b0, 1'b0);
                1: run_refresh($urandom_range(3, 1), 1'b0, 1'b0);
                2: run_refresh(0, 1'b1, 1'b0);
                3: run_refresh(0, 1'b0, 1'b1);
                4: run_dma(1'b0);
                default: run_dma(1'b1);
            endcase
            cyc(3);
            cmp(holdfalls == hf + 1, "hold release count");
        end
        cmp(exp_q.size() == 0, "missing strobe");
        tally_and_finish();
    end
endmodule : tb_top
